// ===== common/violation_log_pkg.sv
package violation_log_pkg;

	localparam logic [8:0] OFS_IRQ_STATUS   = 9'h000;
	localparam logic [8:0] OFS_RD_HEADER    = 9'h100;
	localparam logic [8:0] OFS_RD_MASTER_ID = 9'h104;
	localparam logic [8:0] OFS_RD_ADDR_LOW  = 9'h108;
	localparam logic [8:0] OFS_RD_ADDR_HIGH = 9'h10c;
	localparam logic [8:0] OFS_WR_HEADER    = 9'h190;
	localparam logic [8:0] OFS_WR_MASTER_ID = 9'h194;
	localparam logic [8:0] OFS_WR_ADDR_LOW  = 9'h198;
	localparam logic [8:0] OFS_WR_ADDR_HIGH = 9'h19c;
	localparam logic [8:0] OFS_WR_DATA_0    = 9'h1a0;
	localparam logic [8:0] OFS_WR_DATA_1    = 9'h1a4;
	localparam logic [8:0] OFS_WR_DATA_2    = 9'h1a8;
	localparam logic [8:0] OFS_WR_DATA_3    = 9'h1ac;

	localparam int BIT_WR_VIOL = 0;
	localparam int BIT_RD_VIOL = 1;
	localparam int BIT_WR_OVFL = 2;
	localparam int BIT_RD_OVFL = 3;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] LOG_RESET    = 32'h0000_0000;

	localparam int HDR_VALID_POS = 0;
	localparam int HDR_PROT_POS  = 1;
	localparam int HDR_SIZE_POS  = 4;
	localparam int HDR_LEN_POS   = 7;
	localparam int HDR_BURST_POS = 11;

	// one logged violating cycle
	typedef struct packed {
		logic [1:0]   burst;
		logic [3:0]   len;
		logic [2:0]   size;
		logic [2:0]   prot;
		logic [31:0]  id;
		logic [63:0]  addr;
		logic [127:0] data;
	} viol_entry_s;

	localparam int ENTRY_W = $bits(viol_entry_s);

	// register port request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [8:0]  addr;
		logic [31:0] wdata;
	} csr_req_s;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10,
		RESP_DECERR = 2'b11
	} axi_resp_e;

endpackage

// ===== core/viol_fifo.sv
`timescale 1ns/10ps
module viol_fifo
	import violation_log_pkg::*;
#(
	parameter int WIDTH = ENTRY_W,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	input  wire logic             flush,
	output logic [WIDTH-1:0]      head,
	output logic                  empty,
	output logic                  full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_push;
	logic             do_pop;

	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign empty   = (count == '0);
	assign full    = (count == (AW+1)'(DEPTH));

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) wr_ptr <= bump(wr_ptr);
			if (do_pop) rd_ptr <= bump(rd_ptr);
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// registered head so read data come from a flop
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			head <= '0;
		end else if (do_push && (empty || (do_pop && count == (AW+1)'(1)))) begin
			head <= push_data;
		end else if (do_pop) begin
			head <= mem[bump(rd_ptr)];
		end
	end
endmodule

// ===== core/access_violation_error_log.sv
`timescale 1ns/10ps
module access_violation_error_log
	import violation_log_pkg::*;
#(
	parameter int LOG_DEPTH  = 4,
	parameter int DATA_WIDTH = 32
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        rd_viol,
	input  wire viol_entry_s rd_viol_info,
	input  wire logic        wr_viol,
	input  wire viol_entry_s wr_viol_info,
	input  wire csr_req_s    csr_req,
	output axi_resp_e        viol_resp,
	output logic             viol_resp_valid,
	output logic [31:0]      csr_rdata,
	output logic             csr_rdata_valid,
	output logic             irq
);
	logic [3:0]  status;
	viol_entry_s rd_head;
	viol_entry_s wr_head;
	logic        rd_empty;
	logic        rd_full;
	logic        wr_empty;
	logic        wr_full;
	logic        rd_pop;
	logic        wr_pop;
	logic        rd_clear;
	logic        wr_clear;
	logic        rd_push;
	logic        wr_push;
	logic [31:0] next_rdata;

	// a log entry is logged while its violation flag is still clear or already set
	assign rd_push  = rd_viol && !rd_full;
	assign wr_push  = wr_viol && !wr_full;
	assign rd_clear = csr_req.write && csr_req.addr == OFS_IRQ_STATUS && csr_req.wdata[BIT_RD_VIOL];
	assign wr_clear = csr_req.write && csr_req.addr == OFS_IRQ_STATUS && csr_req.wdata[BIT_WR_VIOL];
	assign rd_pop   = csr_req.read && csr_req.addr == OFS_RD_ADDR_HIGH;
	assign wr_pop   = csr_req.read && ((csr_req.addr == OFS_WR_DATA_3)
		|| (DATA_WIDTH == 32 && csr_req.addr == OFS_WR_DATA_0));

	viol_fifo #(.WIDTH(ENTRY_W), .DEPTH(LOG_DEPTH)) u_rd_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.push      (rd_push),
		.push_data (rd_viol_info),
		.pop       (rd_pop),
		.flush     (rd_clear && !rd_viol),
		.head      (rd_head),
		.empty     (rd_empty),
		.full      (rd_full)
	);

	viol_fifo #(.WIDTH(ENTRY_W), .DEPTH(LOG_DEPTH)) u_wr_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.push      (wr_push),
		.push_data (wr_viol_info),
		.pop       (wr_pop),
		.flush     (wr_clear && !wr_viol),
		.head      (wr_head),
		.empty     (wr_empty),
		.full      (wr_full)
	);

	function automatic logic [31:0] header(input viol_entry_s e, input logic valid);
		header = '0;
		header[HDR_BURST_POS +: 2] = e.burst;
		header[HDR_LEN_POS +: 4]   = e.len;
		header[HDR_SIZE_POS +: 3]  = e.size;
		header[HDR_PROT_POS +: 3]  = e.prot;
		header[HDR_VALID_POS]      = valid;
	endfunction

	// set wins over write-one-to-clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status <= STATUS_RESET[3:0];
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (csr_req.write && csr_req.addr == OFS_IRQ_STATUS && csr_req.wdata[i]) begin
					status[i] <= 1'b0;
				end
			end
			if (rd_viol) status[BIT_RD_VIOL] <= 1'b1;
			if (wr_viol) status[BIT_WR_VIOL] <= 1'b1;
			if (rd_viol && rd_full) status[BIT_RD_OVFL] <= 1'b1;
			if (wr_viol && wr_full) status[BIT_WR_OVFL] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status[1:0]) || rd_viol || wr_viol;
		end
	end

	// log words read as zero when their flag is clear
	always_comb begin
		next_rdata = LOG_RESET;
		if (csr_req.addr == OFS_IRQ_STATUS) begin
			next_rdata = {28'h0, status};
		end else if (csr_req.addr == OFS_RD_HEADER) begin
			next_rdata = header(rd_head, !rd_empty && status[BIT_RD_VIOL]);
		end else if (csr_req.addr == OFS_RD_MASTER_ID) begin
			next_rdata = rd_head.id;
		end else if (csr_req.addr == OFS_RD_ADDR_LOW) begin
			next_rdata = rd_head.addr[31:0];
		end else if (csr_req.addr == OFS_RD_ADDR_HIGH) begin
			next_rdata = rd_head.addr[63:32];
		end else if (csr_req.addr == OFS_WR_HEADER) begin
			next_rdata = header(wr_head, !wr_empty && status[BIT_WR_VIOL]);
		end else if (csr_req.addr == OFS_WR_MASTER_ID) begin
			next_rdata = wr_head.id;
		end else if (csr_req.addr == OFS_WR_ADDR_LOW) begin
			next_rdata = wr_head.addr[31:0];
		end else if (csr_req.addr == OFS_WR_ADDR_HIGH) begin
			next_rdata = wr_head.addr[63:32];
		end else if (csr_req.addr == OFS_WR_DATA_0) begin
			next_rdata = wr_head.data[31:0];
		end else if (csr_req.addr == OFS_WR_DATA_1) begin
			next_rdata = wr_head.data[63:32];
		end else if (csr_req.addr == OFS_WR_DATA_2) begin
			next_rdata = wr_head.data[95:64];
		end else if (csr_req.addr == OFS_WR_DATA_3) begin
			next_rdata = wr_head.data[127:96];
		end
		if ((csr_req.addr[8] && !status[BIT_RD_VIOL] && csr_req.addr < OFS_WR_HEADER)
			|| (csr_req.addr >= OFS_WR_HEADER && !status[BIT_WR_VIOL])) begin
			next_rdata = LOG_RESET;
		end
	end

	// log writes decode to nothing and leave fifo state alone
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			csr_rdata       <= LOG_RESET;
			csr_rdata_valid <= 1'b0;
		end else begin
			csr_rdata_valid <= csr_req.read;
			if (csr_req.read) csr_rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			viol_resp       <= RESP_OKAY;
			viol_resp_valid <= 1'b0;
		end else begin
			viol_resp_valid <= rd_viol || wr_viol;
			viol_resp       <= (rd_viol || wr_viol) ? RESP_DECERR : RESP_OKAY;
		end
	end

	a_rd_pops_entry: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_pop && !rd_empty && !rd_push && !(rd_clear && !rd_viol) |=> $past(u_rd_fifo.count) - 1 == u_rd_fifo.count)
		else $error("read high word did not pop");
	a_wr_pops_entry: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_pop && !wr_empty && !wr_push && !(wr_clear && !wr_viol) |=> $past(u_wr_fifo.count) - 1 == u_wr_fifo.count)
		else $error("write data word did not pop");
	a_rd_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_viol |=> status[BIT_RD_VIOL] ##1 irq) else $error("read flag not set");
	a_wr_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_viol |=> status[BIT_WR_VIOL]) else $error("write flag not set");
	a_ovfl_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_viol && rd_full && !rd_pop |=> status[BIT_RD_OVFL] && u_rd_fifo.full) else $error("overflow lost");
	a_valid_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_clear && !rd_viol |=> rd_empty && !status[BIT_RD_VIOL]) else $error("valid not cleared");
	a_hdr_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(csr_rdata_valid) && $past(csr_req.addr) == OFS_RD_HEADER |-> csr_rdata[31:13] == '0)
		else $error("reserved header bits set");
	a_decerr_resp: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(rd_viol || wr_viol) |=> viol_resp_valid && viol_resp == RESP_DECERR) else $error("no error response");
	a_log_ro: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.write && csr_req.addr != OFS_IRQ_STATUS && !rd_viol && !rd_pop |=> $stable(u_rd_fifo.count))
		else $error("log write changed fifo");

	// fifo bookkeeping: entries move only on violation, pop or flush

	a_wr_ovfl_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_viol && wr_full && !wr_pop |=> status[BIT_WR_OVFL] && u_wr_fifo.full)
		else $error("write overflow lost");

	a_wr_valid_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_clear && !wr_viol |=> wr_empty && !status[BIT_WR_VIOL])
		else $error("write valid not cleared");

	a_rd_push_logs: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_viol && !rd_full |=> !rd_empty)
		else $error("read violation not logged");

	a_wr_push_logs: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_viol && !wr_full |=> !wr_empty)
		else $error("write violation not logged");

	a_wr_log_ro: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.write && csr_req.addr != OFS_IRQ_STATUS && !wr_viol && !wr_pop |=> $stable(u_wr_fifo.count))
		else $error("log write changed write fifo");

	a_rd_stray_pop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!rd_pop && !rd_viol && !rd_clear |=> $stable(u_rd_fifo.count))
		else $error("read fifo moved without cause");

	a_wr_stray_pop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!wr_pop && !wr_viol && !wr_clear |=> $stable(u_wr_fifo.count))
		else $error("write fifo moved without cause");

	a_data0_pop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_WR_DATA_0 |-> wr_pop == (DATA_WIDTH == 32))
		else $error("data word 0 pop mismatch");

	a_ovfl_w1c: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.write && csr_req.addr == OFS_IRQ_STATUS && csr_req.wdata[BIT_RD_OVFL]
		&& !(rd_viol && rd_full) |=> !status[BIT_RD_OVFL]) else $error("read overflow not cleared");

	a_wr_ovfl_w1c: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.write && csr_req.addr == OFS_IRQ_STATUS && csr_req.wdata[BIT_WR_OVFL]
		&& !(wr_viol && wr_full) |=> !status[BIT_WR_OVFL]) else $error("write overflow not cleared");

	a_ovfl_only_full: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!status[BIT_RD_OVFL] && !(rd_viol && rd_full) |=> !status[BIT_RD_OVFL])
		else $error("read overflow set without full");

	// register read words

	a_rd_log_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr[8] && csr_req.addr < OFS_WR_HEADER && !status[BIT_RD_VIOL]
		|=> csr_rdata == '0) else $error("read log visible while flag clear");

	a_wr_log_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr >= OFS_WR_HEADER && !status[BIT_WR_VIOL]
		|=> csr_rdata == '0) else $error("write log visible while flag clear");

	a_rd_valid_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_RD_HEADER && rd_empty |=> !csr_rdata[HDR_VALID_POS])
		else $error("read valid set with empty log");

	a_wr_valid_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_WR_HEADER && wr_empty |=> !csr_rdata[HDR_VALID_POS])
		else $error("write valid set with empty log");

	a_rd_hdr_fields: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_RD_HEADER && status[BIT_RD_VIOL]
		|=> csr_rdata[12:1] == $past({rd_head.burst, rd_head.len, rd_head.size, rd_head.prot}))
		else $error("read header fields misplaced");

	a_wr_hdr_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_rdata_valid && $past(csr_req.addr) == OFS_WR_HEADER |-> csr_rdata[31:13] == '0)
		else $error("reserved write header bits set");

	a_rd_id_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_RD_MASTER_ID && status[BIT_RD_VIOL]
		|=> csr_rdata == $past(rd_head.id)) else $error("read master id wrong");

	a_wr_id_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_WR_MASTER_ID && status[BIT_WR_VIOL]
		|=> csr_rdata == $past(wr_head.id)) else $error("write master id wrong");

	a_rd_addr_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_RD_ADDR_HIGH && status[BIT_RD_VIOL]
		|=> csr_rdata == $past(rd_head.addr[63:32])) else $error("read address high wrong");

	a_wr_data_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
		csr_req.read && csr_req.addr == OFS_WR_DATA_2 && status[BIT_WR_VIOL]
		|=> csr_rdata == $past(wr_head.data[95:64])) else $error("write data word 2 wrong");

	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!csr_req.read |=> $stable(csr_rdata) && !csr_rdata_valid)
		else $error("read data moved without read");

	// response and interrupt

	a_resp_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!rd_viol && !wr_viol |=> !viol_resp_valid && viol_resp == RESP_OKAY)
		else $error("stray error response");

	a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
		status[1:0] != 2'b00 |=> irq)
		else $error("interrupt low with flag set");

	a_irq_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		status[1:0] == 2'b00 && !rd_viol && !wr_viol |=> !irq)
		else $error("interrupt high with flags clear");
endmodule

// ===== dv/viol_source.sv
`timescale 1ns/10ps
module viol_source
	import violation_log_pkg::*;
(
	input  wire logic   clk_sys,
	output logic        rd_viol,
	output viol_entry_s rd_viol_info,
	output logic        wr_viol,
	output viol_entry_s wr_viol_info
);
	initial begin
		rd_viol = 1'b0;
		wr_viol = 1'b0;
		rd_viol_info = '0;
		wr_viol_info = '0;
	end
	// one-cycle pulse with its fields; fields go stale (inverted) afterwards
	task automatic fire(input logic is_wr, input viol_entry_s e);
		@(negedge clk_sys);
		if (is_wr) begin
			wr_viol = 1'b1;
			wr_viol_info = e;
		end else begin
			rd_viol = 1'b1;
			rd_viol_info = e;
		end
		@(negedge clk_sys);
		rd_viol = 1'b0;
		wr_viol = 1'b0;
		rd_viol_info = ~rd_viol_info;
		wr_viol_info = ~wr_viol_info;
	endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/10ps
module testbench;
	import violation_log_pkg::*;
	logic        clk_sys;
	logic        rst_b;
	logic        rd_viol;
	logic        wr_viol;
	viol_entry_s rd_viol_info;
	viol_entry_s wr_viol_info;
	csr_req_s    csr_req;
	axi_resp_e   viol_resp;
	logic        viol_resp_valid;
	logic [31:0] csr_rdata;
	logic        csr_rdata_valid;
	logic        irq;
	int          n_errors;
	int          samples_checked;
	viol_entry_s ea;
	viol_entry_s eb;
	logic [8:0]  ofs [14];

	access_violation_error_log #(.LOG_DEPTH(2), .DATA_WIDTH(128)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.rd_viol(rd_viol), .rd_viol_info(rd_viol_info), .wr_viol(wr_viol), .wr_viol_info(wr_viol_info),
		.csr_req(csr_req), .viol_resp(viol_resp), .viol_resp_valid(viol_resp_valid),
		.csr_rdata(csr_rdata), .csr_rdata_valid(csr_rdata_valid), .irq(irq));
	viol_source src (.clk_sys(clk_sys), .rd_viol(rd_viol), .rd_viol_info(rd_viol_info),
		.wr_viol(wr_viol), .wr_viol_info(wr_viol_info));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic csr_wr(input logic [8:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		csr_req = '{1'b0, 1'b1, a, d};
		@(negedge clk_sys);
		csr_req = '0;
	endtask

	task automatic csr_rd(input logic [8:0] a, input logic [31:0] exp, input string what,
		input logic [31:0] mask = 32'hffff_ffff);
		@(negedge clk_sys);
		csr_req = '{1'b1, 1'b0, a, 32'h0};
		@(negedge clk_sys);
		csr_req = '0;
		chk({what, "_vld"}, 32'h1, {31'h0, csr_rdata_valid});
		chk(what, exp, csr_rdata & mask);
	endtask

	task automatic viol(input logic w, input viol_entry_s e);
		src.fire(w, e);
		chk("resp_vld", 32'h1, {31'h0, viol_resp_valid});
		chk("resp", 32'h3, {30'h0, viol_resp});
	endtask

	function automatic logic [31:0] hdr(input viol_entry_s e);
		return {19'h0, e.burst, e.len, e.size, e.prot, 1'b1};
	endfunction

	initial begin
		#20000;
		n_errors++;
		$display("Error watchdog expired");
		complete_run();
	end

	initial begin
		rst_b = 1'b0;
		csr_req = '0;
		n_errors = 0;
		samples_checked = 0;
		ea = '{2'h1, 4'h9, 3'h5, 3'h6, 32'hcafe_0001, 64'h0000_0012_8000_0040, 128'h0};
		eb = '{2'h2, 4'hf, 3'h2, 3'h1, 32'h0000_00a5, 64'h8765_4321_0bad_f00c,
			128'h4444_4444_3333_3333_2222_2222_1111_1111};
		ofs = '{OFS_IRQ_STATUS, OFS_RD_HEADER, OFS_RD_MASTER_ID, OFS_RD_ADDR_LOW, OFS_RD_ADDR_HIGH,
			OFS_WR_HEADER, OFS_WR_MASTER_ID, OFS_WR_ADDR_LOW, OFS_WR_ADDR_HIGH, OFS_WR_DATA_0,
			OFS_WR_DATA_1, OFS_WR_DATA_2, OFS_WR_DATA_3, 9'h050};
		repeat (6) @(negedge clk_sys);
		rst_b = 1'b1;
		foreach (ofs[i])
			csr_rd(ofs[i], LOG_RESET, "reset_val");
		$display("test reset done");
		viol(1'b0, ea);
		repeat (2) @(negedge clk_sys);
		chk("irq", 32'h1, {31'h0, irq});
		csr_rd(OFS_IRQ_STATUS, 32'h2, "status");
		csr_wr(OFS_RD_HEADER, 32'hffff_ffff);
		csr_rd(OFS_RD_HEADER, hdr(ea), "rd_hdr");
		csr_rd(OFS_RD_MASTER_ID, ea.id, "rd_id");
		csr_rd(OFS_RD_ADDR_LOW, ea.addr[31:0], "rd_alo");
		csr_rd(OFS_RD_ADDR_HIGH, ea.addr[63:32], "rd_ahi");
		csr_rd(OFS_RD_HEADER, 32'h0, "rd_popped", 32'h1);
		csr_wr(OFS_IRQ_STATUS, 32'h2);
		csr_rd(OFS_IRQ_STATUS, 32'h0, "status");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test read log done");
		viol(1'b1, eb);
		csr_rd(OFS_IRQ_STATUS, 32'h1, "status");
		csr_rd(OFS_WR_HEADER, hdr(eb), "wr_hdr");
		csr_rd(OFS_WR_MASTER_ID, eb.id, "wr_id");
		csr_rd(OFS_WR_ADDR_LOW, eb.addr[31:0], "wr_alo");
		csr_rd(OFS_WR_ADDR_HIGH, eb.addr[63:32], "wr_ahi");
		for (int k = 0; k < 4; k++)
			csr_rd(OFS_WR_DATA_0 + 9'(4 * k), eb.data[32 * k +: 32], "wr_data");
		csr_rd(OFS_WR_HEADER, 32'h0, "wr_popped", 32'h1);
		csr_wr(OFS_IRQ_STATUS, 32'h1);
		$display("test write log done");
		for (int k = 0; k < 3; k++)
			viol(1'b0, k == 0 ? ea : eb);
		csr_rd(OFS_IRQ_STATUS, 32'ha, "status");
		csr_wr(OFS_IRQ_STATUS, 32'h8);
		csr_rd(OFS_IRQ_STATUS, 32'h2, "status");
		csr_rd(OFS_RD_HEADER, hdr(ea), "rd_hdr");
		csr_wr(OFS_IRQ_STATUS, 32'h2);
		csr_rd(OFS_RD_HEADER, 32'h0, "rd_hdr_clr");
		for (int k = 0; k < 3; k++)
			viol(1'b1, eb);
		csr_rd(OFS_IRQ_STATUS, 32'h5, "status");
		csr_wr(OFS_IRQ_STATUS, 32'h5);
		csr_rd(OFS_IRQ_STATUS, 32'h0, "status");
		csr_rd(OFS_WR_HEADER, 32'h0, "wr_hdr_clr");
		$display("test overflow done");
		complete_run();
	end
endmodule
